// ### wst_pkg.sv
package wst_pkg;
	localparam int WST_AW = 12;
	localparam int WST_DW = 32;
	// register indices; byte address is four times the index
	localparam logic [7:0] WST_IDX_CTRL = 8'hDC;
	localparam logic [7:0] WST_IDX_CNT = 8'hDD;
	localparam logic [7:0] WST_IDX_STAT = 8'hDE;
	localparam logic [7:0] WST_IDX_MASK = 8'hDF;
	localparam logic [11:0] WST_ADDR_CTRL = {2'h0, WST_IDX_CTRL, 2'h0};
	localparam logic [11:0] WST_ADDR_CNT = {2'h0, WST_IDX_CNT, 2'h0};
	localparam logic [11:0] WST_ADDR_STAT = {2'h0, WST_IDX_STAT, 2'h0};
	localparam logic [11:0] WST_ADDR_MASK = {2'h0, WST_IDX_MASK, 2'h0};
	// control field layout
	localparam int WST_SIG_MSB = 7;
	localparam int WST_SIG_LSB = 4;
	localparam int WST_SEL_MSB = 3;
	localparam int WST_SEL_LSB = 2;
	localparam int WST_CNT_CLR_BIT = 1;
	localparam int WST_PRE_CLR_BIT = 0;
	localparam logic [3:0] WST_SIG_OFF = 4'hA;
	localparam logic [1:0] WST_SEL_4096 = 2'h0;
	localparam logic [1:0] WST_SEL_1024 = 2'h1;
	localparam logic [1:0] WST_SEL_128 = 2'h2;
	// divider ratios
	localparam int WST_DIV_4096 = 4096;
	localparam int WST_DIV_1024 = 1024;
	localparam int WST_DIV_128 = 128;
	localparam int WST_CNT_W = 8;
	// reset values
	localparam logic [7:0] WST_CTRL_RST = 8'h00;
	localparam logic [7:0] WST_CNT_RST = 8'h00;
	localparam logic [1:0] WST_IRQ_RST = 2'h0;
	// status bit positions
	localparam int WST_ST_OVF_BIT = 0;
	localparam int WST_ST_STAB_BIT = 1;
	localparam logic [1:0] WST_RESP_OKAY = 2'h0;
	localparam logic [1:0] WST_RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [3:0] signature;
		logic [1:0] clk_sel;
	} wst_ctrl_t;

	typedef struct packed {
		logic stab_done;
		logic overflow;
	} wst_irq_t;

	typedef enum logic [1:0] {
		WST_RUN = 2'b00,
		WST_STOP = 2'b01,
		WST_STAB = 2'b10
	} wst_state_t;
endpackage : wst_pkg

// ### wst_watchdog_stabilizer_timer.sv
`timescale 1ns/1ps
// Summary of operation
// - reset clears control, watchdog on, divide 4096
// - signature 1010 alone disables the watchdog
// - writing one to bit 1 clears counter
// - bit 0 clears both timer prescalers
// - clock select picks 4096, 1024 or 128
// - counter is read only to software
// - enabled overflow out of bit 7 resets
// - after reset or wakeup oscillator runs, counts
// - counter bit 7 set re-enables CPU clock
module wst_watchdog_stabilizer_timer
	import wst_pkg::*;
#(
	parameter int CNT_W = WST_CNT_W,
	parameter int DIV_SLOW = WST_DIV_4096,
	parameter int DIV_MID = WST_DIV_1024,
	parameter int DIV_FAST = WST_DIV_128
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [WST_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [WST_DW-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [WST_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [WST_DW-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic stop_request,
	input wire logic wake_interrupt,
	output logic wdt_reset_req,
	output logic cpu_clock_enable,
	output logic stabilized_pulse,
	output logic gp_prescaler_clear,
	output logic counter_overflow_pulse,
	output logic irq
);
	localparam int L_SLOW = $clog2(DIV_SLOW);
	localparam int L_MID = $clog2(DIV_MID);
	localparam int L_FAST = $clog2(DIV_FAST);

	wst_ctrl_t wdt_control_reg;
	logic [CNT_W-1:0] wdt_counter_reg;
	logic [L_SLOW-1:0] presc;
	wst_state_t state;
	wst_irq_t status;
	wst_irq_t mask;

	logic aw_held;
	logic w_held;
	logic [WST_AW-1:0] aw_addr;
	logic [WST_DW-1:0] w_data;
	logic [3:0] w_strb;
	logic wr_do;
	logic wr_lane;
	logic wr_ctrl;
	logic wr_stat;
	logic wr_mask;
	logic cnt_clr;
	logic pre_clr;
	logic count_tick;
	logic tap_slow;
	logic tap_mid;
	logic tap_fast;
	logic osc_run;
	logic cnt_full;
	logic wake_now;
	logic stab_hit;
	logic rd_was_ctrl;
	logic [WST_DW-1:0] next_rdata;
	logic [1:0] next_rresp;

	// write side of the bus slave
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign wr_do = aw_held && w_held && !s_axi_bvalid;
	assign wr_lane = wr_do && w_strb[0];
	assign wr_ctrl = wr_lane && (aw_addr == WST_ADDR_CTRL);
	assign wr_stat = wr_lane && (aw_addr == WST_ADDR_STAT);
	assign wr_mask = wr_lane && (aw_addr == WST_ADDR_MASK);
	// strobes act only in the write cycle and are never stored
	assign cnt_clr = wr_ctrl && w_data[WST_CNT_CLR_BIT];
	assign pre_clr = wr_ctrl && w_data[WST_PRE_CLR_BIT];

	always_ff @(posedge clock) begin
		if (rst) begin
			aw_held <= 1'b0;
			aw_addr <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end else if (wr_do) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			w_held <= 1'b0;
			w_data <= '0;
			w_strb <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end else if (wr_do) begin
			w_held <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= WST_RESP_OKAY;
		end else if (wr_do) begin
			s_axi_bvalid <= 1'b1;
			// the counter word is decoded but ignores writes
			case (aw_addr)
				WST_ADDR_CTRL, WST_ADDR_CNT, WST_ADDR_STAT, WST_ADDR_MASK: begin
					s_axi_bresp <= WST_RESP_OKAY;
				end
				default: begin
					s_axi_bresp <= WST_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// read side of the bus slave
	assign s_axi_arready = !s_axi_rvalid;

	always_comb begin
		next_rdata = '0;
		next_rresp = WST_RESP_OKAY;
		case (s_axi_araddr)
			WST_ADDR_CTRL: begin
				next_rdata[WST_SIG_MSB:WST_SEL_LSB] = wdt_control_reg;
			end
			WST_ADDR_CNT: begin
				next_rdata[CNT_W-1:0] = wdt_counter_reg;
			end
			WST_ADDR_STAT: begin
				next_rdata[1:0] = status;
			end
			WST_ADDR_MASK: begin
				next_rdata[1:0] = mask;
			end
			default: begin
				next_rresp = WST_RESP_SLVERR;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= WST_RESP_OKAY;
			rd_was_ctrl <= 1'b0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
			rd_was_ctrl <= (s_axi_araddr == WST_ADDR_CTRL);
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// control register
	always_ff @(posedge clock) begin
		if (rst) begin
			wdt_control_reg <= wst_ctrl_t'(WST_CTRL_RST[WST_SIG_MSB:WST_SEL_LSB]);
		end else if (wr_ctrl) begin
			wdt_control_reg <= wst_ctrl_t'(w_data[WST_SIG_MSB:WST_SEL_LSB]);
		end
	end

	// prescaler runs only while the oscillator is up
	assign osc_run = (state != WST_STOP);

	always_ff @(posedge clock) begin
		if (rst || pre_clr) begin
			presc <= '0;
		end else if (osc_run) begin
			presc <= presc + 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			gp_prescaler_clear <= 1'b0;
		end else begin
			gp_prescaler_clear <= pre_clr;
		end
	end

	// taps of the shared divider feed the counter clock mux
	assign tap_slow = &presc[L_SLOW-1:0];
	assign tap_mid = &presc[L_MID-1:0];
	assign tap_fast = &presc[L_FAST-1:0];

	always_comb begin
		count_tick = 1'b0;
		case (wdt_control_reg.clk_sel)
			WST_SEL_4096: begin
				count_tick = tap_slow;
			end
			WST_SEL_1024: begin
				count_tick = tap_mid;
			end
			WST_SEL_128: begin
				count_tick = tap_fast;
			end
			default: begin
				count_tick = tap_fast;
			end
		endcase
		count_tick = count_tick && osc_run && !pre_clr;
	end

	assign cnt_full = &wdt_counter_reg;
	assign wake_now = (state == WST_STOP) && wake_interrupt;

	// counter changes only by counting, clear strobe, wakeup and reset
	always_ff @(posedge clock) begin
		if (rst || cnt_clr || wake_now) begin
			wdt_counter_reg <= WST_CNT_RST[CNT_W-1:0];
		end else if (count_tick) begin
			wdt_counter_reg <= wdt_counter_reg + 1'b1;
		end
	end

	// overflow out of the top bit; clear in the same cycle cancels it
	always_ff @(posedge clock) begin
		if (rst) begin
			counter_overflow_pulse <= 1'b0;
		end else begin
			counter_overflow_pulse <= count_tick && cnt_full && !cnt_clr;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			wdt_reset_req <= 1'b0;
		end else begin
			// any field value but the signature keeps the reset armed
			wdt_reset_req <= count_tick && cnt_full && !cnt_clr
				&& (wdt_control_reg.signature != WST_SIG_OFF);
		end
	end

	// stop and stabilization sequence; reset lands in stabilization
	assign stab_hit = (state == WST_STAB) && wdt_counter_reg[CNT_W-1];

	always_ff @(posedge clock) begin
		if (rst) begin
			state <= WST_STAB;
		end else begin
			case (state)
				WST_RUN: begin
					if (stop_request) begin
						state <= WST_STOP;
					end
				end
				WST_STOP: begin
					if (wake_interrupt) begin
						state <= WST_STAB;
					end
				end
				WST_STAB: begin
					if (wdt_counter_reg[CNT_W-1]) begin
						state <= WST_RUN;
					end
				end
				default: begin
					state <= WST_STAB;
				end
			endcase
		end
	end

	assign cpu_clock_enable = (state == WST_RUN);

	always_ff @(posedge clock) begin
		if (rst) begin
			stabilized_pulse <= 1'b0;
		end else begin
			stabilized_pulse <= stab_hit;
		end
	end

	// sticky status, write one to clear; a new event beats the clear
	always_ff @(posedge clock) begin
		if (rst) begin
			status <= wst_irq_t'(WST_IRQ_RST);
		end else begin
			status.overflow <= counter_overflow_pulse
				|| (status.overflow && !(wr_stat && w_data[WST_ST_OVF_BIT]));
			status.stab_done <= stabilized_pulse
				|| (status.stab_done && !(wr_stat && w_data[WST_ST_STAB_BIT]));
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			mask <= wst_irq_t'(WST_IRQ_RST);
		end else if (wr_mask) begin
			mask <= wst_irq_t'(w_data[1:0]);
		end
	end

	assign irq = |(status & mask);

	AST_RESET_CTRL: assert property (@(posedge clock)
		rst |=> (wdt_control_reg == '0) && (wdt_counter_reg == '0))
		else $error("control or counter not cleared by reset");

	AST_SIG_DISABLE: assert property (@(posedge clock) disable iff (rst)
		(count_tick && cnt_full && !cnt_clr && wdt_control_reg.signature == WST_SIG_OFF)
		|=> !wdt_reset_req)
		else $error("reset raised with watchdog disabled");

	AST_CNT_CLEAR: assert property (@(posedge clock) disable iff (rst)
		cnt_clr |=> (wdt_counter_reg == '0) && !counter_overflow_pulse)
		else $error("counter clear strobe had no effect");

	AST_PRE_CLEAR: assert property (@(posedge clock) disable iff (rst)
		pre_clr |=> (presc == '0) && gp_prescaler_clear ##1 !gp_prescaler_clear)
		else $error("prescaler clear missing or not one-shot");

	AST_TAP_SEL: assert property (@(posedge clock) disable iff (rst)
		(wdt_control_reg.clk_sel == WST_SEL_4096) && !(&presc) && !cnt_clr && !wake_now
		|=> $stable(wdt_counter_reg))
		else $error("slow divider selected but counter ticked off its tap");

	AST_CNT_READONLY: assert property (@(posedge clock) disable iff (rst)
		(wr_do && aw_addr == WST_ADDR_CNT && !count_tick && !wake_now)
		|=> $stable(wdt_counter_reg))
		else $error("software write altered the counter");

	AST_OVF_RESET: assert property (@(posedge clock) disable iff (rst)
		(count_tick && cnt_full && !cnt_clr && wdt_control_reg.signature != WST_SIG_OFF)
		|=> wdt_reset_req && counter_overflow_pulse && (wdt_counter_reg == '0))
		else $error("enabled overflow did not request reset");

	AST_WAKE_START: assert property (@(posedge clock) disable iff (rst)
		wake_now |=> (state == WST_STAB) && (wdt_counter_reg == '0) && !cpu_clock_enable)
		else $error("wakeup did not start stabilization");

	AST_STAB_DONE: assert property (@(posedge clock) disable iff (rst)
		stab_hit |=> cpu_clock_enable && stabilized_pulse)
		else $error("cpu clock not released after bit 7 set");

	AST_STROBE_READ: assert property (@(posedge clock) disable iff (rst)
		s_axi_rvalid && rd_was_ctrl |-> (s_axi_rdata[1:0] == 2'h0))
		else $error("clear strobes read back nonzero");
endmodule : wst_watchdog_stabilizer_timer

// ### wst_cpu_partner.sv
`timescale 1ns/1ps
module wst_cpu_partner (
	input wire logic clock,
	input wire logic por,
	input wire logic stop_cmd,
	input wire logic wake_cmd,
	input wire logic wdt_reset_req,
	input wire logic cpu_clock_enable,
	output logic rst,
	output logic stop_request,
	output logic wake_interrupt
);
	logic [2:0] hold;
	// a watchdog request becomes a full system reset of several edges
	always_ff @(posedge clock) begin
		if (por) begin
			hold <= 3'h0;
		end else if (wdt_reset_req) begin
			hold <= 3'h5;
		end else if (hold != 3'h0) begin
			hold <= hold - 3'h1;
		end
	end
	assign rst = por || (hold != 3'h0);
	// the core asks for stop only while running; the external wakeup is seen whenever the CPU clock is off, in stop or stabilization
	assign stop_request = stop_cmd && cpu_clock_enable;
	assign wake_interrupt = wake_cmd && !cpu_clock_enable;
endmodule : wst_cpu_partner

// ### tb_basic_timer_watchdog_stabilizer.sv
`timescale 1ns/1ps
module tb_basic_timer_watchdog_stabilizer;
	import wst_pkg::*;
	localparam int DS = 16;
	localparam int DM = 8;
	localparam int DF = 4;
	logic clock = 1'h0, por = 1'h1, stop_cmd = 1'h0, wake_cmd = 1'h0;
	logic rst, stop_request, wake_interrupt;
	logic [WST_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [WST_DW-1:0] s_axi_wdata = '0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic wdt_reset_req, cpu_clock_enable, stabilized_pulse;
	logic gp_prescaler_clear, counter_overflow_pulse, irq;
	int fails = 0, tests_run = 0, n_wdt = 0, n_gp = 0, n_ovf = 0, n_stab = 0, cyc_n = 0;
	int t0, c, g, w;
	int dv[4] = '{DS, DM, DF, DF};
	logic [34:0] expq[$];
	logic [31:0] rnd = 32'd11;
	logic [31:0] v;
	logic [3:0] s;

	initial forever #25 clock = ~clock;

	wst_watchdog_stabilizer_timer #(.DIV_SLOW(DS), .DIV_MID(DM), .DIV_FAST(DF))
		wst_watchdog_stabilizer_timer_inst (
		.clock, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .stop_request, .wake_interrupt,
		.wdt_reset_req, .cpu_clock_enable, .stabilized_pulse, .gp_prescaler_clear,
		.counter_overflow_pulse, .irq);

	wst_cpu_partner wst_cpu_partner_inst (.clock, .por, .stop_cmd, .wake_cmd,
		.wdt_reset_req, .cpu_clock_enable, .rst, .stop_request, .wake_interrupt);

	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs

	task automatic chk(input logic [34:0] got, input logic [34:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic test_done;
		$display("checks=%0d mismatches=%0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : test_done

	// event counters use nonblocking updates so waiting tasks never race them
	always @(posedge clock) begin
		cyc_n <= cyc_n + 1;
		n_wdt <= n_wdt + int'(wdt_reset_req);
		n_gp <= n_gp + int'(gp_prescaler_clear);
		n_ovf <= n_ovf + int'(counter_overflow_pulse);
		n_stab <= n_stab + int'(stabilized_pulse);
	end

	// every bus answer takes the oldest note; notes without the top bit are not compared
	always @(posedge clock) begin
		if (s_axi_bvalid && s_axi_bready) begin
			if (expq[0][34]) chk({1'h1, s_axi_bresp, 32'h0}, expq[0]);
			void'(expq.pop_front());
		end
		if (s_axi_rvalid && s_axi_rready) begin
			if (expq[0][34]) chk({1'h1, s_axi_rresp, s_axi_rdata}, expq[0]);
			void'(expq.pop_front());
		end
	end

	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
		input logic [34:0] note, output logic [31:0] q);
		logic pa, pw, pb;
		int n;
		pa = 1'h1;
		pw = wr;
		pb = 1'h1;
		n = 0;
		q = '0;
		expq.push_back(note);
		if (wr) begin
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'h1;
			s_axi_wvalid <= 1'h1;
			s_axi_bready <= 1'h1;
		end else begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'h1;
			s_axi_rready <= 1'h1;
		end
		while (pa || pw || pb) begin
			@(posedge clock);
			n++;
			if (pa && (wr ? s_axi_awready : s_axi_arready)) begin
				pa = 1'h0;
				s_axi_awvalid <= 1'h0;
				s_axi_arvalid <= 1'h0;
			end
			if (pw && s_axi_wready) begin
				pw = 1'h0;
				s_axi_wvalid <= 1'h0;
			end
			if (pb && (wr ? s_axi_bvalid : s_axi_rvalid)) begin
				pb = 1'h0;
				q = s_axi_rdata;
				s_axi_bready <= 1'h0;
				s_axi_rready <= 1'h0;
			end
			if (n > 100) begin
				fails++;
				test_done();
			end
		end
		// one idle edge so the next call never rewrites a ready or valid in this step
		@(posedge clock);
	endtask : bus

	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
		logic [31:0] q;
		bus(1'h1, a, d, {1'h1, r, 32'h0}, q);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
		logic [31:0] q;
		bus(1'h0, a, 32'h0, {1'h1, r, e}, q);
	endtask : rd

	task automatic rdv(input logic [11:0] a, output logic [31:0] q);
		bus(1'h0, a, 32'h0, 35'h0, q);
	endtask : rdv

	// event selector: 0 stabilization, 1 overflow, other watchdog reset
	function automatic int evn(input int which);
		case (which)
			0: return n_stab;
			1: return n_ovf;
			default: return n_wdt;
		endcase
	endfunction : evn

	task automatic await(input int which, input int lim, output int k);
		int s0;
		s0 = evn(which);
		k = 0;
		while (evn(which) == s0) begin
			@(posedge clock);
			k++;
			if (k > lim) begin
				fails++;
				test_done();
			end
		end
	endtask : await

	initial begin
		repeat (6) @(posedge clock);
		por <= 1'h0;
		t0 = cyc_n;
		rd(WST_ADDR_CTRL, 32'h0, WST_RESP_OKAY);
		rd(WST_ADDR_CNT, 32'h0, WST_RESP_OKAY);
		rd(12'h000, 32'h0, WST_RESP_SLVERR);
		wr(12'h000, 32'h0, WST_RESP_SLVERR);
		chk(35'(cpu_clock_enable), 35'h0);
		await(0, 140 * DS, c);
		chk(35'(cyc_n - t0 >= 128 * DS - 8 && cyc_n - t0 <= 128 * DS + 20), 35'h1);
		chk(35'(cpu_clock_enable), 35'h1);
		rd(WST_ADDR_STAT, 32'h2, WST_RESP_OKAY);
		chk(35'(irq), 35'h0);
		wr(WST_ADDR_MASK, 32'h3, WST_RESP_OKAY);
		chk(35'(irq), 35'h1);
		wr(WST_ADDR_STAT, 32'h2, WST_RESP_OKAY);
		rd(WST_ADDR_STAT, 32'h0, WST_RESP_OKAY);
		chk(35'(irq), 35'h0);
		for (int i = 0; i < 4; i++) begin
			g = n_gp;
			wr(WST_ADDR_CTRL, {24'h0, 4'hA, 2'(i), 2'h3}, WST_RESP_OKAY);
			rd(WST_ADDR_CTRL, {24'h0, 4'hA, 2'(i), 2'h0}, WST_RESP_OKAY);
			chk(35'(n_gp - g), 35'h1);
			repeat (40 * dv[i]) @(posedge clock);
			rdv(WST_ADDR_CNT, v);
			chk(35'(v >= 40 && v <= 42), 35'h1);
		end
		wr(WST_ADDR_CNT, 32'hFF, WST_RESP_OKAY);
		rdv(WST_ADDR_CNT, v);
		chk(35'(v < 32'h40), 35'h1);
		w = n_wdt;
		wr(WST_ADDR_CTRL, 32'hAA, WST_RESP_OKAY);
		await(1, 256 * DF + 40, c);
		chk(35'(c >= 256 * DF - 14 && c <= 256 * DF + 6), 35'h1);
		repeat (2) @(posedge clock);
		chk(35'(n_wdt - w), 35'h0);
		rd(WST_ADDR_STAT, 32'h1, WST_RESP_OKAY);
		chk(35'(irq), 35'h1);
		rnd = xs(rnd);
		s = rnd[3:0];
		if (s == WST_SIG_OFF) s = 4'h3;
		// regular clears keep an armed watchdog quiet
		for (int i = 0; i < 3; i++) begin
			wr(WST_ADDR_CTRL, {24'h0, s, 2'h2, 2'h2}, WST_RESP_OKAY);
			repeat (200 * DF) @(posedge clock);
		end
		chk(35'(n_wdt - w), 35'h0);
		await(2, 256 * DF + 40, c);
		chk(35'(c >= 56 * DF - 10 && c <= 56 * DF + 10), 35'h1);
		repeat (10) @(posedge clock);
		rd(WST_ADDR_CTRL, 32'h0, WST_RESP_OKAY);
		chk(35'(cpu_clock_enable), 35'h0);
		await(0, 140 * DS, c);
		wr(WST_ADDR_CTRL, 32'hAA, WST_RESP_OKAY);
		stop_cmd <= 1'h1;
		@(posedge clock);
		stop_cmd <= 1'h0;
		repeat (3) @(posedge clock);
		chk(35'(cpu_clock_enable), 35'h0);
		rdv(WST_ADDR_CNT, v);
		repeat (100) @(posedge clock);
		rd(WST_ADDR_CNT, v, WST_RESP_OKAY);
		wake_cmd <= 1'h1;
		await(0, 140 * DF, c);
		wake_cmd <= 1'h0;
		chk(35'(c >= 128 * DF - 12 && c <= 128 * DF + 18), 35'h1);
		chk(35'(cpu_clock_enable), 35'h1);
		test_done();
	end
endmodule : tb_basic_timer_watchdog_stabilizer
